// ### jtd_map.svh
// constants of the scan port controller and its instruction decoder
// What this block does
// R1: sixteen-state controller steered by sampled mode select
// R2: separate data scan and instruction scan paths
// R3: instruction length parameter: 10, 14 or 22
// R4: common low six bits, upper bits ones
// R5: external, sample and internal tests use boundary chain
// R6: two codes select two user scan chains
// R7: 64-bit configuration chain for readback and writing
// R8: 32-bit user code and identification chains
// R9: high-impedance code floats pins, bypass connected
// R10: startup stepped by test clock when selected
// R11: shutdown stepped by test clock
// R12: reprogram code acts like program pin
// R13: all-ones code selects one-bit bypass
// R14: boundary scan overrides configuration mode selection
// R15: host avoids boundary tests during configuration
// R16: user chains usable only after configuration
// R17: boundary chain has three bits per pin
// R18: instruction capture loads device status bits
// R19: input taken on rise, output changed on fall
// R20: output driven only while shifting
// R21: bypass captures zero in capture-data state
// R22: unlisted codes connect the bypass bit
// R23: five high rises reach reset; reset loads identification
`ifndef JTD_MAP_SVH
`define JTD_MAP_SVH
`define JTD_IR_LEN 10
`define JTD_OP_LEN 10
`define JTD_NUM_IO 4
`define JTD_BSR_LEN 12
`define JTD_BSR_BITS 3
`define JTD_BSR_OE 0
`define JTD_BSR_OUT 1
`define JTD_BSR_IN 2
`define JTD_OP_EXTEST 10'h3c0
`define JTD_OP_SAMPLE 10'h3c1
`define JTD_OP_USER_A 10'h3c2
`define JTD_OP_USER_B 10'h3c3
`define JTD_OP_CFG_RD 10'h3c4
`define JTD_OP_CFG_WR 10'h3c5
`define JTD_OP_INTEST 10'h3c7
`define JTD_OP_USERCODE 10'h3c8
`define JTD_OP_IDCODE 10'h3c9
`define JTD_OP_HIGHZ 10'h3ca
`define JTD_OP_REPROG 10'h3cb
`define JTD_OP_STARTUP 10'h3cc
`define JTD_OP_SHUTDOWN 10'h3cd
`define JTD_OP_BYPASS 10'h3ff
`define JTD_IR_FIXED 2'h1
`define JTD_ID_LEN 32
`define JTD_CFG_LEN 64
`define JTD_ID_VALUE 32'h0a5a5a5b
`define JTD_RESET_RISES 5
`endif

// ### jtd_pkg.sv
// types of the scan port controller
package jtd_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jtd_state_t;
  typedef enum logic [3:0] {
    I_EXTEST, I_SAMPLE, I_INTEST, I_USER_A, I_USER_B, I_CFG_RD, I_CFG_WR,
    I_USERCODE, I_IDCODE, I_HIGHZ, I_REPROG, I_STARTUP, I_SHUTDOWN, I_BYPASS
  } jtd_instr_t;
endpackage

// ### jtd_tap.sv
// test access port controller with instruction register and decoder
`timescale 1ns/10ps
`default_nettype none
`include "jtd_map.svh"
module jtd_tap #(
  parameter int IR_LEN = `JTD_IR_LEN // R3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic cfg_done_i,
  input wire logic startup_clock_source,
  input wire logic [31:0] user_code_i,
  input wire logic [63:0] cfg_rd_data_i,
  output logic [63:0] cfg_wr_data_q,
  output logic cfg_wr_valid_q,
  output logic scan_clocked_startup,
  output logic scan_clocked_shutdown,
  output logic scan_reprogram_request,
  output logic scan_overrides_mode,
  output logic user_scan_reg_a_select,
  output logic user_scan_reg_b_select,
  input wire logic user_tdo_a_i,
  input wire logic user_tdo_b_i,
  output logic user_tdi_q,
  output logic user_capture_q,
  output logic user_shift_q,
  output logic user_update_q,
  input wire logic [`JTD_NUM_IO-1:0] pin_in,
  input wire logic [`JTD_NUM_IO-1:0] core_out,
  input wire logic [`JTD_NUM_IO-1:0] core_oe,
  output logic [`JTD_NUM_IO-1:0] pin_out_q,
  output logic [`JTD_NUM_IO-1:0] pin_oe_q,
  output logic [`JTD_NUM_IO-1:0] core_in_q
);
  // ****************************************
  // functions
  // ****************************************
  // widen a ten-bit code with ones above it
  function automatic logic [IR_LEN-1:0] op(input logic [`JTD_OP_LEN-1:0] c);
    logic [IR_LEN-1:0] r;
    r = '1;
    r[`JTD_OP_LEN-1:0] = c; // R4
    return r;
  endfunction

  // index of one field of pin k in the boundary chain
  function automatic int bidx(input int k, input int f);
    return `JTD_BSR_BITS * k + f;
  endfunction

  // standard controller transitions
  function automatic jtd_pkg::jtd_state_t nxt(input jtd_pkg::jtd_state_t s, input logic m);
    jtd_pkg::jtd_state_t n;
    n = jtd_pkg::TLR;
    case (s)
      jtd_pkg::TLR: n = m ? jtd_pkg::TLR : jtd_pkg::RTI;
      jtd_pkg::RTI: n = m ? jtd_pkg::SEL_DR : jtd_pkg::RTI;
      jtd_pkg::SEL_DR: n = m ? jtd_pkg::SEL_IR : jtd_pkg::CAP_DR;
      jtd_pkg::CAP_DR: n = m ? jtd_pkg::EX1_DR : jtd_pkg::SH_DR;
      jtd_pkg::SH_DR: n = m ? jtd_pkg::EX1_DR : jtd_pkg::SH_DR;
      jtd_pkg::EX1_DR: n = m ? jtd_pkg::UPD_DR : jtd_pkg::PA_DR;
      jtd_pkg::PA_DR: n = m ? jtd_pkg::EX2_DR : jtd_pkg::PA_DR;
      jtd_pkg::EX2_DR: n = m ? jtd_pkg::UPD_DR : jtd_pkg::SH_DR;
      jtd_pkg::UPD_DR: n = m ? jtd_pkg::SEL_DR : jtd_pkg::RTI;
      jtd_pkg::SEL_IR: n = m ? jtd_pkg::TLR : jtd_pkg::CAP_IR;
      jtd_pkg::CAP_IR: n = m ? jtd_pkg::EX1_IR : jtd_pkg::SH_IR;
      jtd_pkg::SH_IR: n = m ? jtd_pkg::EX1_IR : jtd_pkg::SH_IR;
      jtd_pkg::EX1_IR: n = m ? jtd_pkg::UPD_IR : jtd_pkg::PA_IR;
      jtd_pkg::PA_IR: n = m ? jtd_pkg::EX2_IR : jtd_pkg::PA_IR;
      jtd_pkg::EX2_IR: n = m ? jtd_pkg::UPD_IR : jtd_pkg::SH_IR;
      jtd_pkg::UPD_IR: n = m ? jtd_pkg::SEL_DR : jtd_pkg::RTI;
      default: n = jtd_pkg::TLR;
    endcase
    return n;
  endfunction

  // opcode to instruction, unlisted codes fall to bypass
  function automatic jtd_pkg::jtd_instr_t dec(input logic [IR_LEN-1:0] ir);
    jtd_pkg::jtd_instr_t i;
    i = jtd_pkg::I_BYPASS; // R22 R13
    if (ir == op(`JTD_OP_EXTEST)) i = jtd_pkg::I_EXTEST; // R5
    if (ir == op(`JTD_OP_SAMPLE)) i = jtd_pkg::I_SAMPLE; // R5
    if (ir == op(`JTD_OP_INTEST)) i = jtd_pkg::I_INTEST; // R5
    if (ir == op(`JTD_OP_USER_A)) i = jtd_pkg::I_USER_A; // R6
    if (ir == op(`JTD_OP_USER_B)) i = jtd_pkg::I_USER_B; // R6
    if (ir == op(`JTD_OP_CFG_RD)) i = jtd_pkg::I_CFG_RD; // R7
    if (ir == op(`JTD_OP_CFG_WR)) i = jtd_pkg::I_CFG_WR; // R7
    if (ir == op(`JTD_OP_USERCODE)) i = jtd_pkg::I_USERCODE; // R8
    if (ir == op(`JTD_OP_IDCODE)) i = jtd_pkg::I_IDCODE; // R8
    if (ir == op(`JTD_OP_HIGHZ)) i = jtd_pkg::I_HIGHZ; // R9
    if (ir == op(`JTD_OP_REPROG)) i = jtd_pkg::I_REPROG; // R12
    if (ir == op(`JTD_OP_STARTUP)) i = jtd_pkg::I_STARTUP; // R10
    if (ir == op(`JTD_OP_SHUTDOWN)) i = jtd_pkg::I_SHUTDOWN; // R11
    return i;
  endfunction

  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic rst_s1_q, rst_n;
  logic tck_s1_q, tck_s2_q, tck_s3_q, tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;
  logic done_s1_q, done_s2_q;
  logic [`JTD_NUM_IO-1:0] pin_s1_q, pin_s2_q;

  // reset released through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // test port, done and pin inputs pass two flops; the test clock passes a third
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {tck_s1_q, tck_s2_q, tck_s3_q} <= 3'h0;
      {tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q} <= 4'hf;
      {done_s1_q, done_s2_q} <= 2'h0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      {tck_s1_q, tck_s2_q, tck_s3_q} <= {tck, tck_s1_q, tck_s2_q};
      {tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q} <= {tms, tms_s1_q, tdi, tdi_s1_q};
      {done_s1_q, done_s2_q} <= {cfg_done_i, done_s1_q};
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  jtd_pkg::jtd_state_t st_q;
  logic [IR_LEN-1:0] ir_q, ir_sh_q;
  logic byp_q;
  logic [`JTD_ID_LEN-1:0] id_sh_q, uc_sh_q;
  logic [`JTD_CFG_LEN-1:0] cfg_sh_q;
  logic [`JTD_BSR_LEN-1:0] bsr_sh_q, bsr_upd_q;
  logic tdo_q, oe_q;

  // edges of the sampled test clock and decoded instruction
  wire rise = tck_s2_q & ~tck_s3_q;
  wire fall = ~tck_s2_q & tck_s3_q;
  jtd_pkg::jtd_instr_t ins;
  assign ins = dec(ir_q);
  wire use_bsr = (ins == jtd_pkg::I_EXTEST) | (ins == jtd_pkg::I_SAMPLE) | (ins == jtd_pkg::I_INTEST);
  wire drive_bsr = (ins == jtd_pkg::I_EXTEST) | (ins == jtd_pkg::I_INTEST);
  wire highz = (ins == jtd_pkg::I_HIGHZ);
  wire sel_a = (ins == jtd_pkg::I_USER_A) & done_s2_q; // R16
  wire sel_b = (ins == jtd_pkg::I_USER_B) & done_s2_q; // R16
  wire cap_dr = rise & (st_q == jtd_pkg::CAP_DR);
  wire sh_dr = rise & (st_q == jtd_pkg::SH_DR);
  wire upd_dr = rise & (st_q == jtd_pkg::UPD_DR);
  wire in_shift = (st_q == jtd_pkg::SH_DR) | (st_q == jtd_pkg::SH_IR);
  wire [IR_LEN-1:0] ir_capt = {{(IR_LEN-4){1'b0}}, done_s2_q, startup_clock_source, `JTD_IR_FIXED}; // R18

  // serial out of the selected data chain
  logic dr_so;
  always_comb begin
    case (ins)
      jtd_pkg::I_EXTEST, jtd_pkg::I_SAMPLE, jtd_pkg::I_INTEST: dr_so = bsr_sh_q[0];
      jtd_pkg::I_USER_A: dr_so = sel_a ? user_tdo_a_i : byp_q;
      jtd_pkg::I_USER_B: dr_so = sel_b ? user_tdo_b_i : byp_q;
      jtd_pkg::I_CFG_RD, jtd_pkg::I_CFG_WR: dr_so = cfg_sh_q[0];
      jtd_pkg::I_USERCODE: dr_so = uc_sh_q[0];
      jtd_pkg::I_IDCODE: dr_so = id_sh_q[0];
      default: dr_so = byp_q;
    endcase
  end

  // ****************************************
  // controller and instruction register
  // ****************************************
  // state and instruction advance on test clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= jtd_pkg::TLR;
      ir_q <= op(`JTD_OP_IDCODE);
      ir_sh_q <= '0;
    end else if (rise) begin
      st_q <= nxt(st_q, tms_s2_q); // R1
      if (st_q == jtd_pkg::TLR) ir_q <= op(`JTD_OP_IDCODE); // R23
      if (st_q == jtd_pkg::CAP_IR) ir_sh_q <= ir_capt; // R18
      if (st_q == jtd_pkg::SH_IR) ir_sh_q <= {tdi_s2_q, ir_sh_q[IR_LEN-1:1]}; // R2
      if (st_q == jtd_pkg::UPD_IR) ir_q <= ir_sh_q;
    end
  end

  // ****************************************
  // data chains
  // ****************************************
  // bypass, identification, user code and configuration chains
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_q <= 1'b0;
      id_sh_q <= '0;
      uc_sh_q <= '0;
      cfg_sh_q <= '0;
    end else if (cap_dr) begin
      byp_q <= 1'b0; // R21
      id_sh_q <= `JTD_ID_VALUE; // R8
      uc_sh_q <= user_code_i; // R8
      if (ins == jtd_pkg::I_CFG_RD) cfg_sh_q <= cfg_rd_data_i; // R7
    end else if (sh_dr) begin
      byp_q <= tdi_s2_q; // R13 R2
      id_sh_q <= {tdi_s2_q, id_sh_q[`JTD_ID_LEN-1:1]};
      uc_sh_q <= {tdi_s2_q, uc_sh_q[`JTD_ID_LEN-1:1]};
      cfg_sh_q <= {tdi_s2_q, cfg_sh_q[`JTD_CFG_LEN-1:1]}; // R7
    end
  end

  // configuration write word handed over on update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wr_data_q <= '0;
      cfg_wr_valid_q <= 1'b0;
    end else begin
      cfg_wr_valid_q <= upd_dr & (ins == jtd_pkg::I_CFG_WR); // R7
      if (upd_dr & (ins == jtd_pkg::I_CFG_WR)) cfg_wr_data_q <= cfg_sh_q;
    end
  end

  // boundary chain: per pin oe nearest output, then out, then in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_sh_q <= '0;
      bsr_upd_q <= '0;
    end else if (use_bsr) begin
      if (cap_dr) begin
        for (int k = 0; k < `JTD_NUM_IO; k++) begin
          bsr_sh_q[bidx(k, `JTD_BSR_OE) +: `JTD_BSR_BITS] <= {pin_s2_q[k], core_out[k], core_oe[k]}; // R17
        end
      end
      if (sh_dr) bsr_sh_q <= {tdi_s2_q, bsr_sh_q[`JTD_BSR_LEN-1:1]}; // R5
      if (upd_dr) bsr_upd_q <= bsr_sh_q;
    end
  end

  // pins from the chain in test, floated in high-impedance mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      core_in_q <= '0;
    end else begin
      for (int k = 0; k < `JTD_NUM_IO; k++) begin
        pin_out_q[k] <= drive_bsr ? bsr_upd_q[bidx(k, `JTD_BSR_OUT)] : core_out[k]; // R5
        pin_oe_q[k] <= highz ? 1'b0 : drive_bsr ? bsr_upd_q[bidx(k, `JTD_BSR_OE)] : core_oe[k]; // R9
        core_in_q[k] <= (ins == jtd_pkg::I_INTEST) ? bsr_upd_q[bidx(k, `JTD_BSR_IN)] : pin_s2_q[k];
      end
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  // output changes only on test clock fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (fall) begin
      tdo_q <= (st_q == jtd_pkg::SH_IR) ? ir_sh_q[0] : dr_so; // R19
      oe_q <= in_shift; // R20
    end
  end
  assign tdo_o = tdo_q;
  assign tdo_oe = oe_q;

  // ****************************************
  // configuration control and user chains
  // ****************************************
  // control actions and user chain strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_clocked_startup <= 1'b0;
      scan_clocked_shutdown <= 1'b0;
      scan_reprogram_request <= 1'b0;
      scan_overrides_mode <= 1'b0;
      user_scan_reg_a_select <= 1'b0;
      user_scan_reg_b_select <= 1'b0;
      user_tdi_q <= 1'b1;
      user_capture_q <= 1'b0;
      user_shift_q <= 1'b0;
      user_update_q <= 1'b0;
    end else begin
      scan_clocked_startup <= rise & (st_q == jtd_pkg::RTI) & (ins == jtd_pkg::I_STARTUP) & startup_clock_source; // R10
      scan_clocked_shutdown <= rise & (st_q == jtd_pkg::RTI) & (ins == jtd_pkg::I_SHUTDOWN); // R11
      scan_reprogram_request <= (ins == jtd_pkg::I_REPROG); // R12
      scan_overrides_mode <= use_bsr; // R14 R15
      user_scan_reg_a_select <= sel_a; // R6
      user_scan_reg_b_select <= sel_b; // R6
      user_tdi_q <= tdi_s2_q;
      user_capture_q <= cap_dr & (sel_a | sel_b);
      user_shift_q <= sh_dr & (sel_a | sel_b);
      user_update_q <= upd_dr & (sel_a | sel_b);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // counts rises with mode select high in a row
  logic [2:0] ones_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ones_q <= 3'h0;
    else if (rise) ones_q <= !tms_s2_q ? 3'h0 : (ones_q == 3'h7) ? ones_q : ones_q + 3'h1;
  end

  property p_five_ones;
    (ones_q >= 3'(`JTD_RESET_RISES)) |-> (st_q == jtd_pkg::TLR);
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("five high rises did not reach reset"); // R23
  property p_reset_ir;
    rise && st_q == jtd_pkg::TLR |=> ir_q == op(`JTD_OP_IDCODE);
  endproperty
  a_reset_ir: assert property (p_reset_ir) else $error("reset did not load identification"); // R23
  property p_idle_hold;
    rise && st_q == jtd_pkg::RTI && !tms_s2_q |=> st_q == jtd_pkg::RTI;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left with select low"); // R1
  property p_oe_shift;
    fall |=> (tdo_oe == $past(in_shift));
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("output enable outside shift"); // R20
  property p_tdo_fall;
    !$stable(tdo_o) |-> $past(fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("output changed off falling edge"); // R19
  property p_byp_zero;
    cap_dr |=> !byp_q;
  endproperty
  a_byp_zero: assert property (p_byp_zero) else $error("bypass did not capture zero"); // R21
  property p_ir_capt;
    rise && st_q == jtd_pkg::CAP_IR |=> ir_sh_q[1:0] == `JTD_IR_FIXED;
  endproperty
  a_ir_capt: assert property (p_ir_capt) else $error("instruction capture pattern wrong"); // R18
  property p_highz;
    (ins == jtd_pkg::I_HIGHZ) [*2] |-> pin_oe_q == '0;
  endproperty
  a_highz: assert property (p_highz) else $error("pins driven in high-impedance mode"); // R9
  property p_user_gate;
    user_scan_reg_a_select || user_scan_reg_b_select |-> $past(done_s2_q);
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user chain before configuration"); // R16
  property p_startup;
    scan_clocked_startup |-> $past(startup_clock_source) && $past(ins == jtd_pkg::I_STARTUP);
  endproperty
  a_startup: assert property (p_startup) else $error("startup step without its source"); // R10

  c_ir_shift: cover property (rise && st_q == jtd_pkg::SH_IR);
  c_cfg_write: cover property (cfg_wr_valid_q);
  c_startup: cover property (scan_clocked_startup);
  c_user_a: cover property (user_shift_q && user_scan_reg_a_select);
endmodule
`default_nettype wire

// ### jtd_host.sv
// host model driving the test access port pins
`timescale 1ns/10ps
`default_nettype none
module jtd_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  output logic oe_seen
);
  logic tdo_w;
  logic oe_now;
  // three-state data out, pulled up on the board when released
  assign tdo_w = tdo_oe ? tdo_o : 1'b1;
  // test clock stands low between frames, pulled-up inputs idle high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    oe_seen = 1'b1;
  end
  // one 125 ns period; mode and data move while the clock is low
  // every pin change sits off the system clock's edges to avoid races
  task automatic step(input logic m, input logic d, output logic q);
    #1.25;
    tms = m;
    tdi = d;
    #61.25;
    q = tdo_w;
    oe_now = tdo_oe;
    tck = 1'b1;
    #61.25;
    tck = 1'b0;
    #1.25;
  endtask
  // n rises at a fixed mode level
  task automatic idle(input int n, input logic m);
    logic q;
    repeat (n) step(m, 1'b1, q);
  endtask
  // whole scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    idle(2, 1'b0);
    oe_seen = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
      oe_seen &= oe_now;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// ### jtag_tap_instruction_decoder_tb.sv
// self-checking bench of the scan port controller
`timescale 1ns/10ps
`default_nettype none
`include "jtd_map.svh"
module jtag_tap_instruction_decoder_tb;
  logic clk, resetn, tck, tms, tdi, tdo_o, tdo_oe, cfg_done, src, oe_seen;
  logic wr_v, su, sd, rp, ovr, sel_a, sel_b, utdi, ucap, ush, uupd;
  logic [31:0] ucode, seed;
  logic [63:0] rd, wdat, r, d;
  logic [3:0] pin_in, core_out, core_oe, pout, poe, cin, sr, s4;
  logic [7:0] wr_cnt, su_cnt, sd_cnt, cap_cnt, upd_cnt;
  logic [9:0] ops [9];
  int n_fail, n_tests, cyc, n;
  jtd_tap #(.IR_LEN(`JTD_IR_LEN)) uut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .cfg_done_i(cfg_done), .startup_clock_source(src), .user_code_i(ucode),
    .cfg_rd_data_i(rd), .cfg_wr_data_q(wdat), .cfg_wr_valid_q(wr_v), .scan_clocked_startup(su),
    .scan_clocked_shutdown(sd), .scan_reprogram_request(rp), .scan_overrides_mode(ovr),
    .user_scan_reg_a_select(sel_a), .user_scan_reg_b_select(sel_b), .user_tdo_a_i(sr[0]),
    .user_tdo_b_i(~sr[0]), .user_tdi_q(utdi), .user_capture_q(ucap), .user_shift_q(ush),
    .user_update_q(uupd), .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .pin_out_q(pout),
    .pin_oe_q(poe), .core_in_q(cin));
  jtd_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .oe_seen(oe_seen));
  // system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulse counters and a four-bit user chain
  always @(negedge clk) begin
    wr_cnt <= wr_cnt + 8'(wr_v);
    su_cnt <= su_cnt + 8'(su);
    sd_cnt <= sd_cnt + 8'(sd);
    cap_cnt <= cap_cnt + 8'(ucap);
    upd_cnt <= upd_cnt + 8'(uupd);
    if (ush) sr <= {utdi, sr[3:1]};
  end
  // run limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end
  function automatic logic [63:0] rnd();
    return {$urandom, $urandom};
  endfunction
  // bypass: one zero captured, then the data delayed by a bit
  function automatic logic [63:0] byp(input logic [63:0] x);
    return {56'h0, x[6:0], 1'b0};
  endfunction
  // boundary chain per pin: enable nearest the output, then out, then in
  function automatic logic [63:0] bsr(input logic [3:0] oe, input logic [3:0] o, input logic [3:0] i);
    logic [63:0] v;
    v = '0;
    for (int k = 0; k < `JTD_NUM_IO; k++) v[3*k +: 3] = {i[k], o[k], oe[k]};
    return v;
  endfunction
  function automatic logic [3:0] pick(input logic [63:0] x, input int b);
    logic [3:0] v;
    for (int k = 0; k < 4; k++) v[k] = x[3*k+b];
    return v;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // load an opcode and compare the captured status
  task automatic ld(input logic [9:0] op);
    host.scan(1'b1, `JTD_IR_LEN, {54'h0, op}, r);
    check(r, {60'h0, cfg_done, src, 2'h1});
    check(oe_seen, 1'b1);
  endtask
  task automatic dr(input int k, input logic [63:0] x);
    host.scan(1'b0, k, x, r);
    check(oe_seen, 1'b1);
    check(tdo_oe, 1'b0);
  endtask
  task automatic summarize();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    seed = $urandom(32'h71e9);
    {resetn, cfg_done, src} = 3'b001;
    {ucode, rd} = '0;
    {pin_in, core_out, core_oe, sr, wr_cnt, su_cnt, sd_cnt, cap_cnt, upd_cnt} = '0;
    {n_fail, n_tests, cyc} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    repeat (6) @(negedge clk);
    {pin_in, core_out} = 8'($urandom);
    core_oe = 4'($urandom) | 4'h1;
    check(tdo_oe, 1'b0);
    host.idle(1, 1'b0);
    dr(32, rnd());
    check(r, `JTD_ID_VALUE);
    ops = '{`JTD_OP_BYPASS, `JTD_OP_HIGHZ, `JTD_OP_USER_A, `JTD_OP_USER_B, 10'h3c6, 10'h3ce, 10'h0c9, 10'h000,
      10'h3d0 | 10'($urandom % 47)};
    foreach (ops[k]) begin
      ld(ops[k]);
      check({sel_a, sel_b}, 2'h0);
      check(poe, (ops[k] == `JTD_OP_HIGHZ) ? 4'h0 : core_oe);
      d = rnd();
      dr(8, d);
      check(r, byp(d));
    end
    @(negedge clk) rd = rnd();
    ld(`JTD_OP_CFG_RD);
    dr(64, rnd());
    check(r, rd);
    ld(`JTD_OP_CFG_WR);
    n = wr_cnt;
    d = rnd();
    dr(64, d);
    check(wdat, d);
    check(8'(wr_cnt - n), 8'h1);
    ld(`JTD_OP_REPROG);
    check(rp, 1'b1);
    for (int v = 0; v < 2; v++) begin
      @(negedge clk) src = v[0];
      ld(`JTD_OP_STARTUP);
      check(rp, 1'b0);
      n = su_cnt;
      host.idle(3 + v, 1'b0);
      check(8'(su_cnt - n), 8'(v * 4));
      ld(`JTD_OP_SHUTDOWN);
      n = sd_cnt;
      host.idle(5, 1'b0);
      check(8'(sd_cnt - n), 8'h5);
    end
    check({cap_cnt, upd_cnt}, 16'h0);
    @(negedge clk) cfg_done = 1'b1;
    repeat (4) @(negedge clk);
    ld(`JTD_OP_USER_A);
    check({sel_a, sel_b}, 2'h2);
    s4 = sr;
    d = rnd();
    dr(8, d);
    check(r, {56'h0, d[3:0], s4});
    ld(`JTD_OP_USER_B);
    check({sel_a, sel_b}, 2'h1);
    s4 = sr;
    d = rnd();
    dr(8, d);
    check(r, {56'h0, ~d[3:0], ~s4});
    check({cap_cnt, upd_cnt}, 16'h0202);
    @(negedge clk) ucode = $urandom;
    ld(`JTD_OP_USERCODE);
    dr(32, rnd());
    check(r, ucode);
    @(negedge clk) {pin_in, core_out, core_oe} = 12'($urandom);
    ld(`JTD_OP_SAMPLE);
    check(ovr, 1'b1);
    d = rnd();
    dr(12, d);
    check(r, bsr(core_oe, core_out, pin_in));
    ld(`JTD_OP_EXTEST);
    check(ovr, 1'b1);
    check({pout, poe}, {pick(d, 1), pick(d, 0)});
    ld(`JTD_OP_INTEST);
    d = rnd();
    dr(12, d);
    check(cin, pick(d, 2));
    ld(`JTD_OP_BYPASS);
    check(ovr, 1'b0);
    host.idle(5, 1'b1);
    host.idle(1, 1'b0);
    dr(32, rnd());
    check(r, `JTD_ID_VALUE);
    summarize();
  end
endmodule
`default_nettype wire
